// file: logic/wdg_core.sv
// How it works
// - Low six counter bits set the timeout
// - Timebase code picks period and offset constants
// - Minimum bound: offset-based phase plus ticks
// - Maximum bound: full tick plus same ticks
// - Halt, irq off, option 0: one decrement, freeze
// - External wake from that halt: delayed restart
// - Reset exit leaves watchdog disabled unless hardware
// - Halt, irq off, option 1: immediate reset
// - Halt with irq on: active-halt, counter frozen
// - Interrupt exit from active-halt resumes at once
// - Reset exit from active-halt: delayed restart
// - Hardware option: always active, activation ignored
// - Active and top bit clears: reset
// - Disabled after reset; only reset disables
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "wdg_cfg.svh"

module wdg_core #(
	parameter int TICK_CYCLES = `WDG_TICK_CYCLES,
	parameter int LONG_UNIT   = `WDG_LONG_UNIT,
	parameter bit USE_LONG    = 1'b0
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// CPU and interrupt events, same clock
	input  wire logic       halt_req,
	input  wire logic       ext_irq_wake,
	input  wire logic       tb_irq_wake,
	// Option byte straps, asynchronous pins
	input  wire logic       halt_reset_option,
	input  wire logic       hw_watchdog_option,
	// Halt outcome and reset request
	output logic            halt_enter,
	output logic            wdg_reset_req
);

	// Register state
	logic [7:0] ctrl_ff;          // Activation bit and counter
	logic [7:0] mode_ff;          // Timebase code and irq enable copy
	logic [7:0] rdata_ff;         // Read data, one cycle after strobe
	logic [7:0] nxt_ctrl;         // Next control value
	logic       nxt_rst;          // Reset to request this cycle

	// Strap synchronisers, three stages each
	logic [2:0] hro_sync_ff;      // Halt-reset option chain
	logic [2:0] hwo_sync_ff;      // Hardware option chain
	logic       hro_ff;           // Settled halt-reset option
	logic       hwo_ff;           // Settled hardware option

	// Operating state
	wdg_pkg::wdg_state_e state_ff;      // Current state
	wdg_pkg::wdg_state_e nxt_state;     // Next state
	logic                boot_wait_ff;  // Restart delay pending from reset
	logic                boot_kick_ff;  // High through reset and its first cycle
	logic                halt_enter_ff; // Halt granted strobe
	logic                rst_req_ff;    // Reset request strobe

	// Derived controls
	logic       active;           // Watchdog may reset
	logic       counting;         // Counter decrements on ticks
	logic       presc_run;        // Prescaler clock runs
	logic       tick;             // Decrement strobe
	logic       delay_start;      // Kick the restart delay
	logic       delay_done;       // Restart delay elapsed
	logic       ctrl_wr;          // Write to the control register
	logic       mode_wr;          // Write to the mode register
	wdg_pkg::timebase_t tb_sel;   // Timebase code in use
	logic       tb_irq_enable;    // Timebase interrupt enable
	logic       frozen;           // No reset may leave the block now

	// Register map: control holds the sticky activation bit over the seven
	// counter bits; mode is a local copy of the timebase code and the irq
	// enable, kept here so the block can be tested alone; status is read-only
	// and shows the settled straps, the wait flag and the halt state
	// Address decode, used by both write and read paths
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	assign ctrl_wr       = reg_wr && hit(reg_addr, `WDG_CTRL_ADDR);
	assign mode_wr       = reg_wr && hit(reg_addr, `WDG_MODE_ADDR);
	assign tb_sel        = mode_ff[`WDG_MODE_TB_LSB +: 2];
	assign tb_irq_enable = mode_ff[`WDG_MODE_IE_BIT];

	// Hardware option overrides the activation bit
	assign active = hwo_ff || ctrl_ff[`WDG_ACT_BIT];

	// Counter runs in run and for the last decrement before halt
	assign counting = ((state_ff == wdg_pkg::st_run) && !boot_wait_ff) ||
	                  (state_ff == wdg_pkg::st_halt_last);

	// Divider stops in full halt only; active-halt keeps the timebase alive
	assign presc_run = (state_ff != wdg_pkg::st_halt);

	// The last decrement before a plain halt counts down but must not fire,
	// and both halts hold the counter, so none of these states may reset
	assign frozen = (state_ff == wdg_pkg::st_halt_last) ||
	                (state_ff == wdg_pkg::st_halt) ||
	                (state_ff == wdg_pkg::st_act_halt);

	// The straps come from the option byte and may change at any time relative
	// to the clock, so they pass three flops; a level is only taken once two
	// stages agree, which filters a single metastable sample
	// Strap chains; a change counts once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hro_sync_ff <= 3'h0;
			hwo_sync_ff <= 3'h0;
		end else begin
			hro_sync_ff <= {hro_sync_ff[1:0], halt_reset_option};
			hwo_sync_ff <= {hwo_sync_ff[1:0], hw_watchdog_option};
		end
	end

	// Settled strap values, caught after the release of reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hro_ff <= 1'b0;
			hwo_ff <= 1'b0;
		end else begin
			if (hro_sync_ff[1] == hro_sync_ff[2]) begin
				hro_ff <= hro_sync_ff[2];
			end
			if (hwo_sync_ff[1] == hwo_sync_ff[2]) begin
				hwo_ff <= hwo_sync_ff[2];
			end
		end
	end

	// Running the divider through active-halt keeps the timebase honest, so
	// the first tick after wake lands where it would have without the halt
	// Tick source, phased to the selected timebase
	wdg_prescaler #(
		.TICK_CYCLES     (TICK_CYCLES),
		.LONG_UNIT       (LONG_UNIT)
	) u_presc (
		.core_clk        (core_clk),
		.rst_b           (rst_b),
		.run             (presc_run),
		.timebase_select (tb_sel),
		.tick            (tick)
	);

	// Delay before counting restarts after a halt or a reset
	wdg_restart_delay #(
		.USE_LONG (USE_LONG)
	) u_delay (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.start    (delay_start),
		.done     (delay_done)
	);

	// Delay kicked on external wake from halt, or once after reset
	always_comb begin
		delay_start = 1'b0;
		if ((state_ff == wdg_pkg::st_halt) && ext_irq_wake) begin
			delay_start = 1'b1;
		end
		// Reset release: counting waits the same delay
		if (boot_kick_ff) begin
			delay_start = 1'b1;
		end
	end

	// Power-up wait; the chip reset cannot tell which mode it left, so every
	// release waits, which is harmless while the watchdog is still disabled
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_kick_ff <= 1'b1;
		end else begin
			boot_kick_ff <= 1'b0;
		end
	end

	// Pending wait flag, cleared by the delay end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_wait_ff <= 1'b1;
		end else if (delay_done && (state_ff != wdg_pkg::st_resume)) begin
			boot_wait_ff <= 1'b0;
		end
	end

	// Halt flow in brief:
	//   irq enable set    -> active-halt, counter held, divider keeps running
	//   irq off, option 0 -> one last decrement, then full freeze
	//   irq off, option 1 -> no halt at all, a reset request instead
	// Only an external wake leaves the full freeze, and it pays the restart
	// delay; either wake leaves active-halt at once. A halt request outside
	// run is ignored, as the CPU cannot issue one while it sleeps.
	// Halt handling state machine
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			wdg_pkg::st_run: begin
				// Halt with the irq off and option 1 becomes a reset instead
				if (halt_req && !tb_irq_enable && !hro_ff) begin
					nxt_state = wdg_pkg::st_halt_last;
				end else if (halt_req && tb_irq_enable) begin
					nxt_state = wdg_pkg::st_act_halt;
				end
			end
			wdg_pkg::st_halt_last: begin
				// One more decrement, then freeze
				if (tick) begin
					nxt_state = wdg_pkg::st_halt;
				end
			end
			wdg_pkg::st_halt: begin
				// Only an external interrupt wakes this halt
				if (ext_irq_wake) begin
					nxt_state = wdg_pkg::st_resume;
				end
			end
			wdg_pkg::st_resume: begin
				if (delay_done) begin
					nxt_state = wdg_pkg::st_run;
				end
			end
			wdg_pkg::st_act_halt: begin
				// Either interrupt resumes counting with no delay
				if (tb_irq_wake || ext_irq_wake) begin
					nxt_state = wdg_pkg::st_run;
				end
			end
			default: begin
				nxt_state = wdg_pkg::st_run;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= wdg_pkg::st_run;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Halt granted strobe to the CPU
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			halt_enter_ff <= 1'b0;
		end else begin
			halt_enter_ff <= (state_ff == wdg_pkg::st_run) && halt_req &&
			                 (tb_irq_enable || !hro_ff);
		end
	end

	// Reset causes, all registered into one strobe: rollover of the top bit
	// while active, a software write that clears the top bit while active,
	// and a halt with the irq off and the halt-reset option set. The chip
	// reset that follows clears this block, so the strobe needs no hold.
	// Next control value and reset decision
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_rst  = 1'b0;
		if (counting && tick) begin
			nxt_ctrl[6:0] = ctrl_ff[6:0] - 7'h01;
			// Roll from 40h to 3Fh fires only when active
			if (active && (ctrl_ff[6:0] == `WDG_TOP_THRESH)) begin
				nxt_rst = 1'b1;
			end
		end
		if (ctrl_wr) begin
			// Activation is sticky; only a reset clears it
			nxt_ctrl[`WDG_ACT_BIT] = ctrl_ff[`WDG_ACT_BIT] | reg_wdata[`WDG_ACT_BIT];
			nxt_ctrl[6:0]          = reg_wdata[6:0];
			// Writing the top bit clear while active is a software reset
			if ((hwo_ff || nxt_ctrl[`WDG_ACT_BIT]) && !reg_wdata[`WDG_TOP_BIT]) begin
				nxt_rst = 1'b1;
			end
		end
		if ((state_ff == wdg_pkg::st_run) && halt_req && !tb_irq_enable && hro_ff) begin
			nxt_rst = 1'b1;
		end
		// A frozen counter never resets, nor does the last decrement before halt
		if (frozen) begin
			nxt_rst = 1'b0;
		end
	end

	// Control register; reset leaves it disabled at 7Fh
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= `WDG_CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Mode register, mirror of the clock controller bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_ff <= `WDG_MODE_RESET;
		end else if (mode_wr) begin
			mode_ff <= {5'h00, reg_wdata[2:0]};
		end
	end

	// Reset request strobe; the chip reset that follows clears this block
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_req_ff <= 1'b0;
		end else begin
			rst_req_ff <= nxt_rst;
		end
	end

	// Read data; unmapped addresses read as zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			if (hit(reg_addr, `WDG_CTRL_ADDR)) begin
				rdata_ff <= ctrl_ff;
			end else if (hit(reg_addr, `WDG_MODE_ADDR)) begin
				rdata_ff <= mode_ff;
			end else if (hit(reg_addr, `WDG_STAT_ADDR)) begin
				rdata_ff <= {boot_wait_ff, hwo_ff, hro_ff, active, counting,
				             state_ff};
			end else begin
				rdata_ff <= 8'h00;
			end
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata     = rdata_ff;
	assign halt_enter    = halt_enter_ff;
	assign wdg_reset_req = rst_req_ff;

endmodule

// file: logic/wdg_cfg.svh
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH

// Register addresses on the plain register port
`define WDG_CTRL_ADDR     8'h2a
`define WDG_MODE_ADDR     8'h2b
`define WDG_STAT_ADDR     8'h2c

// Control register layout and reset value
`define WDG_CTRL_RESET    8'h7f
`define WDG_ACT_BIT       7
`define WDG_TOP_BIT       6
`define WDG_TOP_THRESH    7'h40

// Mode register layout and reset value
`define WDG_MODE_RESET    8'h00
`define WDG_MODE_TB_LSB   0
`define WDG_MODE_IE_BIT   2

// Prescaler timing, in oscillator cycles
`define WDG_TICK_CYCLES   16384
`define WDG_LONG_BASE     192
`define WDG_LONG_UNIT     64
`define WDG_PHASE_STEP    4

// Period and offset constants per timebase code
`define WDG_PER_TB0       7'd4
`define WDG_PER_TB1       7'd8
`define WDG_PER_TB2       7'd20
`define WDG_PER_TB3       7'd49
`define WDG_OFS_TB0       8'd59
`define WDG_OFS_TB1       8'd53
`define WDG_OFS_TB2       8'd35
`define WDG_OFS_TB3       8'd54

// Restart delays after a halt, in CPU clock cycles
`define WDG_SHORT_DELAY   256
`define WDG_LONG_DELAY    4096

`endif

// file: logic/wdg_pkg.sv
package wdg_pkg;

	// Timebase code from the clock controller
	typedef logic [1:0] timebase_t;

	// Watchdog operating state, Gray along run-halt-resume
	typedef enum logic [2:0] {
		st_run       = 3'b000,
		st_halt_last = 3'b001,
		st_halt      = 3'b011,
		st_resume    = 3'b010,
		st_act_halt  = 3'b110
	} wdg_state_e;

endpackage

// file: logic/wdg_prescaler.sv
`timescale 1ns/1ps
`include "wdg_cfg.svh"

module wdg_prescaler #(
	parameter int TICK_CYCLES = `WDG_TICK_CYCLES,
	parameter int LONG_UNIT   = `WDG_LONG_UNIT
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	// Control
	input  wire logic             run,
	input  wire wdg_pkg::timebase_t timebase_select,
	// Decrement strobe
	output logic                  tick
);

	// Period constant for a timebase code
	function automatic logic [6:0] period_of(input wdg_pkg::timebase_t tb);
		case (tb)
			2'd0: period_of = `WDG_PER_TB0;
			2'd1: period_of = `WDG_PER_TB1;
			2'd2: period_of = `WDG_PER_TB2;
			default: period_of = `WDG_PER_TB3;
		endcase
	endfunction

	// Offset constant for a timebase code
	function automatic logic [7:0] offset_of(input wdg_pkg::timebase_t tb);
		case (tb)
			2'd0: offset_of = `WDG_OFS_TB0;
			2'd1: offset_of = `WDG_OFS_TB1;
			2'd2: offset_of = `WDG_OFS_TB2;
			default: offset_of = `WDG_OFS_TB3;
		endcase
	endfunction

	logic [13:0] cyc_ff;    // Cycles into the current tick
	logic [6:0]  acc_ff;    // Four times tick index, modulo period
	logic        tick_ff;   // Registered tick strobe
	logic [6:0]  per;       // Period constant now selected
	logic [6:0]  acc_step;  // Accumulator plus one step
	logic        long_tick; // Current tick is the substituted one
	logic [13:0] lim;       // Last cycle index of this tick
	logic        wrap;      // Tick completes this cycle

	// Substitution comes from the phase of the timebase divider
	always_comb begin
		per       = period_of(timebase_select);
		acc_step  = acc_ff + 7'(`WDG_PHASE_STEP);
		long_tick = (acc_step >= per);
		if (long_tick) begin
			lim = 14'((`WDG_LONG_BASE + int'(offset_of(timebase_select))) * LONG_UNIT - 1);
		end else begin
			lim = 14'(TICK_CYCLES - 1);
		end
		wrap = run && (cyc_ff >= lim);
	end

	// Cycle counter; holds while frozen
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc_ff <= 14'h0000;
		end else if (wrap) begin
			cyc_ff <= 14'h0000;
		end else if (run) begin
			cyc_ff <= cyc_ff + 14'h0001;
		end
	end

	// Phase accumulator; a timebase change may leave it above the period
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_ff <= 7'h00;
		end else if (wrap) begin
			acc_ff <= long_tick ? 7'(acc_step - per) : acc_step;
		end
	end

	// Strobe out from a flop
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= wrap;
		end
	end

	assign tick = tick_ff;

endmodule

// file: logic/wdg_restart_delay.sv
`timescale 1ns/1ps
`include "wdg_cfg.svh"

module wdg_restart_delay #(
	parameter bit USE_LONG = 1'b0
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_b,
	// Start a delay, and its end
	input  wire logic start,
	output logic      done
);

	// Delay length fixed at build time
	localparam logic [12:0] DELAY_LAST =
		13'((USE_LONG ? `WDG_LONG_DELAY : `WDG_SHORT_DELAY) - 1);

	logic [12:0] cnt_ff;  // Cycles left
	logic        busy_ff; // Delay running
	logic        done_ff; // End strobe

	// Count down the delay; a new start restarts it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff  <= 13'h0000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				cnt_ff  <= DELAY_LAST;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				if (cnt_ff == 13'h0000) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - 13'h0001;
				end
			end
		end
	end

	assign done = done_ff;

endmodule

// file: tb/wdg_core_checker.sv
`timescale 1ns/1ps
`include "wdg_cfg.svh"

// Port-level checks of halt handling and reset requests
module wdg_core_checker (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Events and straps
	input wire logic       halt_req,
	input wire logic       ext_irq_wake,
	input wire logic       tb_irq_wake,
	input wire logic       halt_reset_option,
	input wire logic       hw_watchdog_option,
	// Outcomes
	input wire logic       halt_enter,
	input wire logic       wdg_reset_req
);
	logic halted_ff; // Inside halt or active-halt
	logic ie_ff;     // Shadow of the irq enable bit
	logic act_ff;    // Shadow of the sticky activate bit
	logic ctrl_wr;   // Write to the control register

	assign ctrl_wr = reg_wr && reg_addr == `WDG_CTRL_ADDR;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Halt tracking, one cycle late so the grant cycle is excluded below
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) halted_ff <= 1'b0;
		else if (ext_irq_wake || tb_irq_wake) halted_ff <= 1'b0;
		else if (halt_enter) halted_ff <= 1'b1;
	end
	// Irq enable shadow
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) ie_ff <= 1'b0;
		else if (reg_wr && reg_addr == `WDG_MODE_ADDR) ie_ff <= reg_wdata[`WDG_MODE_IE_BIT];
	end
	// Activate shadow, cleared only by reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) act_ff <= 1'b0;
		else if (ctrl_wr && reg_wdata[`WDG_ACT_BIT]) act_ff <= 1'b1;
	end

	property p_halt_cause;
		halt_enter |-> $past(halt_req);
	endproperty
	a_halt_cause: assert property (p_halt_cause)
		else $error("halt granted without a halt request");
	property p_halt_pulse;
		halt_enter |=> !halt_enter;
	endproperty
	a_halt_pulse: assert property (p_halt_pulse)
		else $error("halt grant longer than one cycle");
	property p_halt_reset;
		halt_req && !halted_ff && !halt_enter && !ie_ff && halt_reset_option
			|=> wdg_reset_req && !halt_enter;
	endproperty
	a_halt_reset: assert property (p_halt_reset)
		else $error("halt with option set did not reset");
	property p_halt_grant;
		halt_req && !halted_ff && !halt_enter && (ie_ff || !halt_reset_option) |=> halt_enter;
	endproperty
	a_halt_grant: assert property (p_halt_grant)
		else $error("halt not granted");
	property p_frozen;
		halted_ff |-> !wdg_reset_req;
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("reset request while halted");
	property p_sw_reset;
		ctrl_wr && !reg_wdata[`WDG_TOP_BIT] && !halted_ff && !halt_enter
			&& (reg_wdata[`WDG_ACT_BIT] || act_ff || hw_watchdog_option) |=> wdg_reset_req;
	endproperty
	a_sw_reset: assert property (p_sw_reset)
		else $error("top bit cleared while active without reset");
	property p_no_sw;
		ctrl_wr && !reg_wdata[`WDG_ACT_BIT] && !act_ff && !hw_watchdog_option && !halt_req
			|=> !wdg_reset_req;
	endproperty
	a_no_sw: assert property (p_no_sw)
		else $error("reset request while disabled");
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");
endmodule

bind wdg_core wdg_core_checker u_chk (.core_clk(core_clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .halt_req(halt_req), .ext_irq_wake(ext_irq_wake),
	.tb_irq_wake(tb_irq_wake), .halt_reset_option(halt_reset_option),
	.hw_watchdog_option(hw_watchdog_option), .halt_enter(halt_enter),
	.wdg_reset_req(wdg_reset_req));

// file: tb/wdg_core_test.sv
`timescale 1ns/1ps
`include "wdg_cfg.svh"

module wdg_core_test;
	localparam int TICK = 256; // Keeps the 256:1 ratio of tick to unit
	localparam int UNIT = 1;
	logic       core_clk, rst_b, reg_wr, reg_rd, halt_req, ext_w, tb_w, hro, hwo;
	logic       halt_enter, wdg_reset_req;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v;
	int         n_errors, checked, cyc, n;

	wdg_core #(.TICK_CYCLES(TICK), .LONG_UNIT(UNIT), .USE_LONG(1'b0)) uut (
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req),
		.ext_irq_wake(ext_w), .tb_irq_wake(tb_w), .halt_reset_option(hro),
		.hw_watchdog_option(hwo), .halt_enter(halt_enter), .wdg_reset_req(wdg_reset_req));

	// 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task report_and_stop();
		if (n_errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task idle(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask
	// Event pulse: 0 halt, 1 external wake, 2 timebase wake
	task ev(input int w);
		@(posedge core_clk);
		halt_req <= (w == 0);
		ext_w <= (w == 1);
		tb_w <= (w == 2);
		@(posedge core_clk);
		{halt_req, ext_w, tb_w} <= 3'b000;
		#1;
	endtask
	// Cycles until a reset request, bounded
	task wait_req(input int lim);
		#1 n = 0;
		while (wdg_reset_req !== 1'b1 && n < lim) begin
			@(posedge core_clk);
			#1 n++;
		end
	endtask
	// Reset with straps set; waits out the restart delay
	task do_reset(input logic h, input logic w);
		hro <= h;
		hwo <= w;
		rst_b <= 1'b0;
		idle(12);
		rst_b <= 1'b1;
		idle(250);
		rd(`WDG_STAT_ADDR, d);
		chk("boot wait", {d[7], d[3]}, 2'b10);
		idle(48);
	endtask
	task st(input logic [7:0] e);
		rd(`WDG_STAT_ADDR, d);
		chk("state", d[2:0], e);
	endtask
	function automatic int tlim(input int tb, input int c, input bit mx);
		int msb, lsb, k;
		msb = tb == 0 ? 4 : tb == 1 ? 8 : tb == 2 ? 20 : 49;
		lsb = tb == 0 ? 59 : tb == 1 ? 53 : tb == 2 ? 35 : 54;
		k = (mx ? c <= msb / 4 : c < msb / 4) ? 0 : 4 * c / msb;
		return (mx ? TICK : (lsb + 128) * UNIT) + TICK * (c - k) + (192 + lsb) * UNIT * k;
	endfunction

	// Reset values, unmapped and read-only places
	task t_regs();
		rd(`WDG_CTRL_ADDR, d);
		chk("ctrl", d, `WDG_CTRL_RESET);
		rd(`WDG_MODE_ADDR, d);
		chk("mode", d, `WDG_MODE_RESET);
		rd(8'h10, d);
		chk("unmapped", d, 8'h00);
		rd(`WDG_STAT_ADDR, v);
		chk("stat opts", v[6:4], 3'b000);
		chk("boot done", v[7], 1'b0);
		wr(`WDG_STAT_ADDR, 8'hff);
		rd(`WDG_STAT_ADDR, d);
		chk("stat ro", d, v);
	endtask
	// Disabled write, sticky activate, software reset
	task t_soft();
		wr(`WDG_CTRL_ADDR, 8'h3f);
		wait_req(4);
		chk("no req", n, 4);
		wr(`WDG_CTRL_ADDR, 8'hff);
		wr(`WDG_CTRL_ADDR, 8'h7f);
		rd(`WDG_CTRL_ADDR, d);
		chk("sticky", d[7], 1'b1);
		wr(`WDG_CTRL_ADDR, 8'hbf);
		wait_req(4);
		chk("sw req", n < 3, 1'b1);
		do_reset(1'b0, 1'b0);
		rd(`WDG_CTRL_ADDR, d);
		chk("ctrl after rst", d, 8'h7f);
	endtask
	// Timeout inside its bounds for every timebase
	task t_timeout();
		for (int tb = 0; tb < 4; tb++) begin
			do_reset(1'b0, 1'b0);
			wr(`WDG_MODE_ADDR, tb[7:0]);
			wr(`WDG_CTRL_ADDR, 8'hc5);
			wait_req(3000);
			chk("tmo lo", n >= tlim(tb, 5, 1'b0) - 4, 1'b1);
			chk("tmo hi", n <= tlim(tb, 5, 1'b1) + 4, 1'b1);
		end
	endtask
	// Halt with option set resets at once
	task t_opt();
		do_reset(1'b1, 1'b0);
		ev(0);
		chk("halt opt1", {halt_enter, wdg_reset_req}, 2'b01);
	endtask
	// Active-halt freezes; timebase wake resumes at once
	task t_act();
		do_reset(1'b1, 1'b0);
		wr(`WDG_MODE_ADDR, 8'h04);
		wr(`WDG_CTRL_ADDR, 8'hc5);
		ev(0);
		chk("act halt", {halt_enter, wdg_reset_req}, 2'b10);
		st(8'h06);
		rd(`WDG_CTRL_ADDR, v);
		idle(2000);
		rd(`WDG_CTRL_ADDR, d);
		chk("act frozen", d, v);
		ev(2);
		rd(`WDG_STAT_ADDR, d);
		chk("act wake", d[3:0], 4'h8);
		wait_req(2000);
		chk("act resumes", n < 2000, 1'b1);
	endtask
	// Plain halt: one decrement, freeze, delayed restart
	task t_halt();
		do_reset(1'b0, 1'b0);
		wr(`WDG_CTRL_ADDR, 8'hc5);
		rd(`WDG_CTRL_ADDR, v);
		ev(0);
		chk("halt", {halt_enter, wdg_reset_req}, 2'b10);
		st(8'h01);
		idle(600);
		st(8'h03);
		rd(`WDG_CTRL_ADDR, d);
		chk("one dec", d, v - 8'h01);
		ev(1);
		st(8'h02);
		idle(240);
		st(8'h02);
		idle(30);
		st(8'h00);
	endtask
	// Hardware option: active without the activate bit
	task t_hw();
		do_reset(1'b0, 1'b1);
		rd(`WDG_STAT_ADDR, d);
		chk("hw opt", d[6], 1'b1);
		wr(`WDG_CTRL_ADDR, 8'h3f);
		wait_req(4);
		chk("hw req", n < 3, 1'b1);
	endtask

	// Main sequence
	initial begin
		{rst_b, reg_wr, reg_rd, halt_req, ext_w, tb_w, hro, hwo} = 8'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		do_reset(1'b0, 1'b0);
		t_regs();
		t_soft();
		t_timeout();
		t_opt();
		t_act();
		t_halt();
		t_hw();
		report_and_stop();
	end
endmodule
